// ===== src/sensor_consts.svh
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// register addresses on the serial interface
`define ADDR_CHIP_MODE     8'h07
`define ADDR_FIRST_KNEE    8'h08
`define ADDR_SECOND_KNEE   8'h09
`define ADDR_KNEE_CTRL     8'h0a
`define ADDR_TOTAL_INTEG   8'h0b
`define ADDR_RESET         8'h0c

// chip mode control fields
`define CM_SCAN_HI         2
`define CM_SCAN_LO         0
`define CM_INITIATOR       3
`define CM_TRIG_FRAME      4
`define CM_STEREO          5
`define CM_STEREO_ROLE     6
`define CM_PAR_OUT         7
`define CM_OVERLAP         8
`define CM_WIDTH           9

// scan mode codes
`define SCAN_PROGRESSIVE   3'h0
`define SCAN_TWO_FIELD     3'h2
`define SCAN_ONE_FIELD     3'h3

// knee control fields
`define KC_T2_HI           3
`define KC_T2_LO           0
`define KC_T3_HI           7
`define KC_T3_LO           4
`define KC_AUTO            8
`define KC_SINGLE          9
`define KC_WIDTH           10

// reset register bit
`define RST_SOFT           0

// reset values
`define CHIP_MODE_RESET    9'h188
`define FIRST_KNEE_RESET   15'h1bb
`define SECOND_KNEE_RESET  15'h1d9
`define KNEE_CTRL_RESET    10'h164
`define TOTAL_INTEG_RESET  15'h1e0

// pll multipliers
`define PLL_MULT_SINGLE    5'h0c
`define PLL_MULT_STEREO    5'h12

`endif

// ===== src/sensor_pkg.sv
package sensor_pkg;
  typedef enum logic [1:0] {seq_idle, seq_pass_a, seq_pass_b} seq_state_t;
  typedef logic [14:0] rows_t;
  typedef logic [9:0]  row_addr_t;
endpackage

// ===== src/row_sequencer.sv
`timescale 1ns/100ps
`include "sensor_consts.svh"

module row_sequencer (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       next_row,
  input  wire logic [2:0] mode,
  input  wire logic [8:0] row_start,
  input  wire logic [8:0] height,
  output logic      [9:0] row_addr,
  output logic            row_active,
  output logic            frame_done
);

  typedef struct packed {
    sensor_pkg::seq_state_t state;
    sensor_pkg::row_addr_t  row;
    logic                   active;
    logic                   done;
  } seq_t;

  seq_t s;
  seq_t next_s;

  logic [9:0] start_w;
  logic [9:0] last_row;
  logic [9:0] even_first;
  logic [9:0] odd_first;
  logic [9:0] nr;
  logic       two_field;
  logic       one_field;

  // window bounds and the first row of each parity
  always_comb begin
    start_w    = {1'b0, row_start};
    last_row   = start_w + {1'b0, height} - 10'h001;
    even_first = start_w + {9'h000, row_start[0]};
    odd_first  = start_w + {9'h000, ~row_start[0]};
    two_field  = (mode == `SCAN_TWO_FIELD);
    one_field  = (mode == `SCAN_ONE_FIELD);
    nr         = s.row + ((two_field || one_field) ? 10'h002 : 10'h001);
  end

  // walks the window in the order the scan mode asks for;
  // the invalid mode codes (1 and 4 to 7) fall back to progressive order
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.state)
      sensor_pkg::seq_idle: begin
        if (start) begin
          next_s.active = 1'b1;
          next_s.state  = sensor_pkg::seq_pass_a;
          next_s.row    = two_field ? even_first : start_w;
        end
      end
      sensor_pkg::seq_pass_a, sensor_pkg::seq_pass_b: begin
        if (next_row) begin
          if (nr <= last_row) begin
            next_s.row = nr;
          end else if (two_field && s.state == sensor_pkg::seq_pass_a
                       && odd_first <= last_row) begin
            next_s.row   = odd_first;
            next_s.state = sensor_pkg::seq_pass_b;
          end else begin
            next_s.active = 1'b0;
            next_s.done   = 1'b1;
            next_s.state  = sensor_pkg::seq_idle;
          end
        end
      end
      default: next_s.state = sensor_pkg::seq_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign row_addr   = s.row;
  assign row_active = s.active;
  assign frame_done = s.done;

endmodule

// ===== src/sensor_chip_control_regs.sv
`timescale 1ns/100ps
`include "sensor_consts.svh"

module sensor_chip_control_regs (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        frame_start,
  input  wire logic        frame_trigger,
  input  wire logic        ext_exposure_start,
  input  wire logic        exposure_done,
  input  wire logic        row_next,
  input  wire logic [8:0]  row_start,
  input  wire logic [8:0]  window_height,
  input  wire logic        hdr_enable,
  input  wire logic        auto_exposure_control,
  input  wire logic [14:0] aec_integration,
  input  wire logic [9:0]  pixel_in,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output logic      [4:0]  pll_mult,
  output logic             stereo_enable,
  output logic             stereo_secondary,
  output logic             exposure_start,
  output logic             readout_start,
  output logic      [9:0]  dout,
  output logic      [9:0]  dout_oe,
  output logic      [9:0]  row_addr,
  output logic             row_active,
  output logic             rows_done,
  output logic      [14:0] integ_phase1,
  output logic      [14:0] integ_phase2,
  output logic      [14:0] integ_phase3,
  output logic             knee_explicit
);

  typedef struct packed {
    logic [8:0]      chip_pend;
    logic [8:0]      chip_live;
    sensor_pkg::rows_t knee1;
    sensor_pkg::rows_t knee2;
    logic [9:0]      knee_ctrl;
    sensor_pkg::rows_t total;
    logic            free_run;
    logic [15:0]     rdata;
    logic            rvalid;
    logic [4:0]      pll;
    logic            exp_go;
    logic            rd_go;
    logic [9:0]      dout;
    logic [9:0]      oe;
    sensor_pkg::rows_t ph1;
    sensor_pkg::rows_t ph2;
    sensor_pkg::rows_t ph3;
    logic            explicit_knee;
  } ctl_t;

  ctl_t r;
  ctl_t next_r;

  logic              soft_rst;
  logic              go;
  sensor_pkg::rows_t total_use;
  sensor_pkg::rows_t t2;
  sensor_pkg::rows_t t3;

  // soft reset is a self-clearing write; it rebuilds defaults in one cycle
  assign soft_rst = reg_wr && reg_addr == `ADDR_RESET
                    && reg_wdata[`RST_SOFT];

  // frame launch follows the live initiator and trigger bits
  always_comb begin
    if (r.chip_live[`CM_INITIATOR]) begin
      if (r.chip_live[`CM_TRIG_FRAME]) begin
        go = frame_trigger;
      end else begin
        go = r.free_run;
      end
    end else begin
      go = ext_exposure_start;
    end
  end

  // integration length and auto knee durations by halving
  always_comb begin
    total_use = auto_exposure_control ? aec_integration : r.total;
    t2 = total_use >> r.knee_ctrl[`KC_T2_HI:`KC_T2_LO];
    t3 = total_use >> r.knee_ctrl[`KC_T3_HI:`KC_T3_LO];
  end

  always_comb begin
    next_r        = r;
    next_r.rvalid = reg_rd;
    next_r.exp_go = go;
    // overlap lets readout run with exposure, else wait for its end
    next_r.rd_go  = r.chip_live[`CM_OVERLAP] ? go : exposure_done;
    // the first free-running frame starts right after reset
    next_r.free_run = rows_done;

    // register writes land in the pending or immediate copies
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_CHIP_MODE:   next_r.chip_pend = reg_wdata[8:0];
        `ADDR_FIRST_KNEE:  next_r.knee1 = reg_wdata[14:0];
        `ADDR_SECOND_KNEE: next_r.knee2 = reg_wdata[14:0];
        `ADDR_KNEE_CTRL:   next_r.knee_ctrl = reg_wdata[9:0];
        `ADDR_TOTAL_INTEG: next_r.total = reg_wdata[14:0];
        default: ;
      endcase
    end

    // reads return the pending copy; unmapped addresses read zero
    case (reg_addr)
      `ADDR_CHIP_MODE:   next_r.rdata = {7'h00, r.chip_pend};
      `ADDR_FIRST_KNEE:  next_r.rdata = {1'b0, r.knee1};
      `ADDR_SECOND_KNEE: next_r.rdata = {1'b0, r.knee2};
      `ADDR_KNEE_CTRL:   next_r.rdata = {6'h00, r.knee_ctrl};
      `ADDR_TOTAL_INTEG: next_r.rdata = {1'b0, r.total};
      default:           next_r.rdata = 16'h0000;
    endcase

    // frame start: pending mode goes live and knee timing is frozen,
    // so a mid-frame knee write never disturbs the running frame
    if (frame_start) begin
      next_r.chip_live     = r.chip_pend;
      next_r.explicit_knee = hdr_enable && !r.knee_ctrl[`KC_AUTO];
      if (hdr_enable && !r.knee_ctrl[`KC_AUTO]) begin
        next_r.ph1 = r.knee1;
        next_r.ph2 = r.knee2 - r.knee1;
        next_r.ph3 = total_use - r.knee2;
      end else if (hdr_enable) begin
        next_r.ph1 = total_use - t2 - t3;
        next_r.ph2 = t2;
        next_r.ph3 = t3;
      end else begin
        next_r.ph1 = total_use;
        next_r.ph2 = 15'h0000;
        next_r.ph3 = 15'h0000;
      end
    end

    // pll and stereo role follow the live copy
    next_r.pll = r.chip_live[`CM_STEREO] ? `PLL_MULT_STEREO
                                        : `PLL_MULT_SINGLE;
    // parallel pixel bus drives only when enabled
    next_r.oe   = {10{r.chip_live[`CM_PAR_OUT]}};
    next_r.dout = r.chip_live[`CM_PAR_OUT] ? pixel_in : 10'h000;

    // soft reset restores the register and phase defaults and abandons the frame; pll and pixel bus follow the live copy a cycle later
    if (soft_rst) begin
      next_r.chip_pend     = `CHIP_MODE_RESET;
      next_r.chip_live     = `CHIP_MODE_RESET;
      next_r.knee1         = `FIRST_KNEE_RESET;
      next_r.knee2         = `SECOND_KNEE_RESET;
      next_r.knee_ctrl     = `KNEE_CTRL_RESET;
      next_r.total         = `TOTAL_INTEG_RESET;
      next_r.ph1           = `TOTAL_INTEG_RESET;
      next_r.ph2           = 15'h0000;
      next_r.ph3           = 15'h0000;
      next_r.explicit_knee = 1'b0;
      next_r.free_run      = 1'b1;
      next_r.exp_go        = 1'b0;
      next_r.rd_go         = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r               <= '0;
      r.chip_pend     <= `CHIP_MODE_RESET;
      r.chip_live     <= `CHIP_MODE_RESET;
      r.knee1         <= `FIRST_KNEE_RESET;
      r.knee2         <= `SECOND_KNEE_RESET;
      r.knee_ctrl     <= `KNEE_CTRL_RESET;
      r.total         <= `TOTAL_INTEG_RESET;
      r.free_run      <= 1'b1;
      r.pll           <= `PLL_MULT_SINGLE;
      r.ph1           <= `TOTAL_INTEG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // row order generator; a soft reset also drops the frame in flight
  row_sequencer u_rows (
    .mclk       (mclk),
    .rst_n      (rst_n && !soft_rst),
    .start      (r.rd_go),
    .next_row   (row_next),
    .mode       (r.chip_live[`CM_SCAN_HI:`CM_SCAN_LO]),
    .row_start  (row_start),
    .height     (window_height),
    .row_addr   (row_addr),
    .row_active (row_active),
    .frame_done (rows_done)
  );

  assign reg_rdata        = r.rdata;
  assign reg_rvalid       = r.rvalid;
  assign pll_mult         = r.pll;
  assign stereo_enable    = r.chip_live[`CM_STEREO];
  assign stereo_secondary = r.chip_live[`CM_STEREO_ROLE];
  assign exposure_start   = r.exp_go;
  assign readout_start    = r.rd_go;
  assign dout             = r.dout;
  assign dout_oe          = r.oe;
  assign integ_phase1     = r.ph1;
  assign integ_phase2     = r.ph2;
  assign integ_phase3     = r.ph3;
  assign knee_explicit    = r.explicit_knee;

endmodule

// ===== verif/chip_ctrl_sva.sv
`timescale 1ns/100ps
module chip_ctrl_sva (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic        reg_rvalid,
  input wire logic [4:0]  pll_mult,
  input wire logic        stereo_enable,
  input wire logic [9:0]  dout,
  input wire logic [9:0]  dout_oe,
  input wire logic        row_next,
  input wire logic [9:0]  row_addr,
  input wire logic        row_active,
  input wire logic        rows_done,
  input wire logic        frame_start,
  input wire logic [14:0] integ_phase2,
  input wire logic        exposure_start,
  input wire logic        readout_start,
  input wire logic        knee_explicit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // the multiplier is registered from the live bit, one cycle behind it
  pll_sel_a: assert property (
    pll_mult == ($past(stereo_enable) ? 5'h12 : 5'h0c))
    else $error("pll multiplier does not follow stereo bit");
  oe_all_a: assert property (dout_oe == 10'h3ff || dout_oe == 10'h000)
    else $error("output enables split");
  dout_off_a: assert property (dout_oe == 10'h000 |-> dout == 10'h000)
    else $error("pixel bus not quiet while released");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_only_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  row_step_a: assert property (
    row_active && row_next |=> rows_done || !$stable(row_addr))
    else $error("row did not advance");
  phase_hold_a: assert property (
    !frame_start |=> $stable(integ_phase2))
    else $error("phase changed outside frame start");
  expo_pulse_a: assert property (exposure_start |=> !exposure_start)
    else $error("exposure start longer than a pulse");
  cover property (frame_start ##1 knee_explicit);
  cover property (rows_done);
  cover property (exposure_start && readout_start);
endmodule

bind sensor_chip_control_regs chip_ctrl_sva u_chk (.mclk, .rst_n, .reg_rd,
  .reg_rvalid, .pll_mult, .stereo_enable, .dout, .dout_oe, .row_next,
  .row_addr, .row_active, .rows_done, .frame_start, .integ_phase2,
  .exposure_start, .readout_start, .knee_explicit);

// ===== verif/host_model.sv
`timescale 1ns/100ps
module host_model (
  input  wire logic        mclk,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // bus idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_wdata = 16'h0000;
    reg_rd = 1'h0;
  end
  // one-cycle write strobe; data scrambled after so stale data never passes
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge mclk) #1;
    reg_wr = 1'h0;
    reg_wdata = ~d;
  endtask
  // read strobe, then a bounded wait for the answer
  task rd(input logic [7:0] a, output logic [15:0] d);
    int i;
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge mclk) #1;
    reg_rd = 1'h0;
    for (i = 0; i < 4 && reg_rvalid !== 1'h1; i++) @(posedge mclk) #1;
    d = reg_rdata;
  endtask
endmodule

// ===== verif/sensor_chip_control_regs_bench.sv
`timescale 1ns/100ps
module sensor_chip_control_regs_bench;
  logic        mclk, rst_n, reg_wr, reg_rd, frame_start, frame_trigger;
  logic        ext_exposure_start, exposure_done, row_next, hdr_enable;
  logic        auto_exposure_control, reg_rvalid, stereo_enable;
  logic        stereo_secondary, exposure_start, readout_start;
  logic        row_active, rows_done, knee_explicit;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [4:0]  pll_mult;
  logic [8:0]  row_start, window_height;
  logic [14:0] aec_integration, integ_phase1, integ_phase2, integ_phase3;
  logic [9:0]  pixel_in, dout, dout_oe, row_addr;
  logic [9:0]  exp_q[$];
  int          bad_count, cmp_count, exp_cnt, ro_cnt, e0, r0, m, p, r;

  sensor_chip_control_regs u_dut (.mclk, .rst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .frame_start, .frame_trigger, .ext_exposure_start,
    .exposure_done, .row_next, .row_start, .window_height, .hdr_enable,
    .auto_exposure_control, .aec_integration, .pixel_in, .reg_rdata,
    .reg_rvalid, .pll_mult, .stereo_enable, .stereo_secondary,
    .exposure_start, .readout_start, .dout, .dout_oe, .row_addr, .row_active,
    .rows_done, .integ_phase1, .integ_phase2, .integ_phase3, .knee_explicit);
  host_model u_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid);

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // launch pulses are counted so none is missed between glances
  always @(posedge mclk) begin
    if (exposure_start === 1'h1) exp_cnt++;
    if (readout_start === 1'h1) ro_cnt++;
  end
  task chk(input string what, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task cfg(input logic [15:0] v);
    u_host.wr(8'h07, v);
    pulse(frame_start);
    tick(2);
  endtask
  // step through a frame; with check off it only flushes a running one
  // row_next stays high while rows are active so it is never set twice
  // in one time step; an extra row shows up against 3ff
  task rows(input bit check);
    int         i;
    logic [9:0] want;
    for (i = 0; i < 40 && rows_done !== 1'h1; i++) begin
      if (row_active === 1'h1) begin
        if (check) begin
          want = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff;
          chk("row_addr", want, row_addr);
        end
        row_next = 1'h1;
      end else begin
        row_next = 1'h0;
      end
      tick(1);
    end
    row_next = 1'h0;
    chk("frame end", 16'h0001, rows_done);
    if (check) chk("rows left", 16'h0, exp_q.size());
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    results;
  end

  initial begin
    {rst_n, frame_start, frame_trigger, ext_exposure_start} = 4'h0;
    {exposure_done, row_next, hdr_enable, auto_exposure_control} = 4'h0;
    row_start = 9'h004;
    window_height = 9'h006;
    pixel_in = 10'h2a5;
    aec_integration = 15'h0190;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'h1;
    tick(2);
    u_host.rd(8'h07, rd_val);
    chk("chip mode", 16'h0188, rd_val);
    u_host.rd(8'h08, rd_val);
    chk("knee1", 16'h01bb, rd_val);
    u_host.rd(8'h09, rd_val);
    chk("knee2", 16'h01d9, rd_val);
    u_host.rd(8'h3f, rd_val);
    chk("unmapped", 16'h0000, rd_val);
    chk("pll", 16'h000c, pll_mult);
    chk("oe", 16'h03ff, dout_oe);
    chk("dout", 16'h02a5, dout);
    $display("test reset done");
    // stereo secondary with pairing on, parallel bus off, external start
    u_host.wr(8'h07, 16'h0160);
    tick(2);
    chk("pll pending", 16'h000c, pll_mult);
    pulse(frame_start);
    tick(2);
    chk("pll live", 16'h0012, pll_mult);
    chk("oe off", 16'h0000, dout_oe);
    chk("role", 16'h0001, stereo_secondary);
    rows(0);
    $display("test shadow done");
    for (m = 0; m < 4; m++) begin
      if (m == 1) continue;
      cfg(16'h0180 | m);
      exp_q = {};
      for (p = 0; p < 2; p++)
        for (r = row_start; r < row_start + window_height; r++)
          if (m == 0 ? p == 0 : (r % 2 == p) && (m == 2 || p == row_start[0]))
            exp_q.push_back(10'(r));
      pulse(ext_exposure_start);
      rows(1);
    end
    $display("test scan done");
    cfg(16'h0080);
    {e0, r0} = {exp_cnt, ro_cnt};
    pulse(ext_exposure_start);
    tick(4);
    chk("expo ext", 16'(e0 + 1), 16'(exp_cnt));
    chk("readout early", 16'(r0), 16'(ro_cnt));
    pulse(exposure_done);
    tick(2);
    chk("readout seq", 16'(r0 + 1), 16'(ro_cnt));
    rows(0);
    cfg(16'h0198);
    {e0, r0} = {exp_cnt, ro_cnt};
    tick(8);
    chk("no trigger", 16'(e0), 16'(exp_cnt));
    pulse(frame_trigger);
    tick(3);
    chk("triggered", 16'(e0 + 1), 16'(exp_cnt));
    chk("readout sim", 16'(r0 + 1), 16'(ro_cnt));
    rows(0);
    $display("test launch done");
    hdr_enable = 1'h1;
    u_host.wr(8'h0a, 16'h0064);
    u_host.wr(8'h08, 16'h0064);
    u_host.wr(8'h09, 16'h012c);
    tick(2);
    chk("phase2 held", 16'h0000, integ_phase2);
    u_host.rd(8'h08, rd_val);
    chk("knee1 rd", 16'h0064, rd_val);
    pulse(frame_start);
    tick(2);
    chk("phase1", 16'h0064, integ_phase1);
    chk("phase2", 16'h00c8, integ_phase2);
    chk("phase3", 16'h00b4, integ_phase3);
    chk("explicit", 16'h0001, knee_explicit);
    auto_exposure_control = 1'h1;
    pulse(frame_start);
    tick(2);
    chk("phase3 auto", 16'h0064, integ_phase3);
    u_host.wr(8'h0a, 16'h0164);
    pulse(frame_start);
    tick(2);
    chk("auto knee", 16'h0000, knee_explicit);
    chk("ratio t2", 16'h0019, integ_phase2);
    hdr_enable = 1'h0;
    pulse(frame_start);
    tick(2);
    chk("hdr off", 16'h0190, integ_phase1);
    $display("test knee done");
    // soft reset restores defaults and relaunches a free-running frame
    {e0, r0} = {exp_cnt, ro_cnt};
    u_host.wr(8'h0c, 16'h0001);
    tick(3);
    chk("soft expo", 16'(e0 + 1), 16'(exp_cnt));
    chk("soft pll", 16'h000c, pll_mult);
    chk("soft phase1", 16'h01e0, integ_phase1);
    u_host.rd(8'h07, rd_val);
    chk("soft mode", 16'h0188, rd_val);
    u_host.rd(8'h0a, rd_val);
    chk("knee ctrl", 16'h0164, rd_val);
    u_host.rd(8'h0b, rd_val);
    chk("total", 16'h01e0, rd_val);
    u_host.rd(8'h0c, rd_val);
    chk("reset bit", 16'h0000, rd_val);
    rows(0);
    $display("test soft reset done");
    results;
  end
endmodule
